// ### pkg/sgcr_pkg.sv
/*
 * Constants for the switch global control register slice: offsets, reset values,
 * field positions and storm window timing.
 * Assumes an 8-bit register port and a 25 MHz core clock.
 */
package sgcr_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] SGCR_OFS_MII_VID_STORM_HIGH = 8'h06;
   localparam logic [7:0] SGCR_OFS_STORM_RATE_LOW = 8'h07;
   localparam logic [7:0] SGCR_OFS_FACTORY_TEST_A = 8'h08;
   localparam logic [7:0] SGCR_OFS_FACTORY_TEST_B = 8'h09;
   localparam logic [7:0] SGCR_OFS_FACTORY_TEST_C = 8'h0a;
   localparam logic [7:0] SGCR_OFS_LOOPBACK_LED_CONTROL = 8'h0b;

   // ==========================================================
   // Reset values
   localparam logic [7:0] SGCR_RST_MII_VID_STORM_HIGH = 8'h00;
   localparam logic [7:0] SGCR_RST_STORM_RATE_LOW = 8'h63;
   localparam logic [7:0] SGCR_RST_FACTORY_TEST_A = 8'h4e;
   localparam logic [7:0] SGCR_RST_FACTORY_TEST_B = 8'h24;
   localparam logic [7:0] SGCR_RST_FACTORY_TEST_C = 8'h24;
   localparam logic [7:0] SGCR_RST_LOOPBACK_LED_CONTROL = 8'h08;

   // ==========================================================
   // Field positions
   localparam int SGCR_BIT_MII_10M = 4;
   localparam int SGCR_BIT_NULL_VID = 3;
   localparam int SGCR_BIT_STORM_HI_MSB = 2;
   localparam int SGCR_BIT_RESERVED_TOP = 7;
   localparam int SGCR_BIT_CRC_DROP = 5;
   localparam int SGCR_BIT_LB_POS_HI = 3;
   localparam int SGCR_BIT_LB_POS_LO = 2;
   localparam int SGCR_BIT_LED_MODE = 1;

   // ==========================================================
   // Timing
   localparam int SGCR_CLK_HZ = 25_000_000;
   localparam int SGCR_WIN_100_MS = 67;
   localparam int SGCR_WIN_10_MS = 500;
   localparam int SGCR_WIN_100_CYC = (SGCR_CLK_HZ / 1000) * SGCR_WIN_100_MS;
   localparam int SGCR_WIN_10_CYC = (SGCR_CLK_HZ / 1000) * SGCR_WIN_10_MS;
   localparam int SGCR_WIN_W = 24;
   localparam logic [1:0] SGCR_STRAP_SETTLE = 2'h3;
   localparam int SGCR_THR_W = 11;
endpackage

// ### rtl/sgcr_top.sv
/*
 * Global control register slice of a three-port switch: MII speed select,
 * null VLAN ID replacement, broadcast storm threshold and window metering,
 * factory test registers, loop-back error dropping and LED mode select.
 * Assumes a simple strobe register port, straps that settle around reset,
 * one-cycle block/frame pulses from the datapath on core_clk.
 */
module sgcr_top import sgcr_pkg::*; #(
   parameter int NUM_PORTS = 3,
   parameter int WIN_100_CYC = SGCR_WIN_100_CYC,
   parameter int WIN_10_CYC = SGCR_WIN_10_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic mii_rx_bit1_strap,
   input wire logic led_select_low_strap,
   input wire logic led_select_high_strap,
   output logic mii_10m_mode,
   output logic loopback_position_hi,
   output logic loopback_position_lo,
   output logic led_select_low,
   output logic led_select_high,
   input wire logic [NUM_PORTS-1:0] port_is_10m,
   input wire logic [NUM_PORTS-1:0] storm_enable,
   input wire logic [NUM_PORTS-1:0] bcast_block,
   output logic [NUM_PORTS-1:0] storm_drop,
   input wire logic vid_valid_in,
   input wire logic [11:0] vid_in,
   input wire logic [11:0] port_vid,
   output logic vid_valid_out,
   output logic [11:0] vid_out,
   input wire logic loopback_mode,
   input wire logic frame_done,
   input wire logic frame_is_oam,
   input wire logic frame_crc_err,
   input wire logic frame_undersize,
   input wire logic frame_oversize,
   output logic loop_forward,
   output logic loop_drop
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0] gc4;
      logic [7:0] storm_lo;
      logic [7:0] test_a;
      logic [7:0] test_b;
      logic [7:0] test_c;
      logic [7:0] gc9;
      logic [7:0] rdata;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic led_high;
      logic [2:0] sync0;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [NUM_PORTS-1:0][SGCR_WIN_W-1:0] win_cnt;
      logic [NUM_PORTS-1:0][SGCR_THR_W-1:0] blk_cnt;
      logic [NUM_PORTS-1:0] drop;
      logic vid_valid;
      logic [11:0] vid;
      logic lb_fwd;
      logic lb_drop;
   } sgcr_state_s;

   localparam logic [SGCR_WIN_W-1:0] WIN_100_LAST = SGCR_WIN_W'(WIN_100_CYC - 1);
   localparam logic [SGCR_WIN_W-1:0] WIN_10_LAST = SGCR_WIN_W'(WIN_10_CYC - 1);

   sgcr_state_s s_q;
   sgcr_state_s s_d;
   logic [SGCR_THR_W-1:0] threshold;
   logic frame_bad;

   // Upper three bits from the high register, low byte from the next one
   assign threshold = {s_q.gc4[SGCR_BIT_STORM_HI_MSB:0], s_q.storm_lo};
   assign frame_bad = frame_crc_err | frame_undersize | frame_oversize;

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;

      // Straps pass three flops; only the second and third stages are read
      s_d.sync0 = {led_select_high_strap, led_select_low_strap, mii_rx_bit1_strap};
      s_d.sync1 = s_q.sync0;
      s_d.sync2 = s_q.sync1;

      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            SGCR_OFS_MII_VID_STORM_HIGH: s_d.gc4 = reg_wdata;
            SGCR_OFS_STORM_RATE_LOW: s_d.storm_lo = reg_wdata;
            SGCR_OFS_FACTORY_TEST_A: s_d.test_a = reg_wdata;
            SGCR_OFS_FACTORY_TEST_B: s_d.test_b = reg_wdata;
            SGCR_OFS_FACTORY_TEST_C: s_d.test_c = reg_wdata;
            // Top bit is reserved and reads zero; position code is stored as written
            SGCR_OFS_LOOPBACK_LED_CONTROL: begin
               s_d.gc9 = reg_wdata;
               s_d.gc9[SGCR_BIT_RESERVED_TOP] = 1'b0;
            end
            default: ;
         endcase
      end

      // Strap capture once the synchroniser has settled after reset release;
      // it overrides a write made in the same cycle, so wait before writing
      if (!s_q.strap_done) begin
         if (s_q.strap_cnt != SGCR_STRAP_SETTLE) begin
            s_d.strap_cnt = s_q.strap_cnt + 2'h1;
         end else if (s_q.sync1 == s_q.sync2) begin
            s_d.strap_done = 1'b1;
            s_d.gc4[SGCR_BIT_MII_10M] = s_q.sync2[0];
            s_d.gc9[SGCR_BIT_LED_MODE] = s_q.sync2[1];
            s_d.led_high = s_q.sync2[2];
         end
      end

      // Read data stands for one cycle after the strobe
      s_d.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            SGCR_OFS_MII_VID_STORM_HIGH: s_d.rdata = s_q.gc4;
            SGCR_OFS_STORM_RATE_LOW: s_d.rdata = s_q.storm_lo;
            SGCR_OFS_FACTORY_TEST_A: s_d.rdata = s_q.test_a;
            SGCR_OFS_FACTORY_TEST_B: s_d.rdata = s_q.test_b;
            SGCR_OFS_FACTORY_TEST_C: s_d.rdata = s_q.test_c;
            SGCR_OFS_LOOPBACK_LED_CONTROL: s_d.rdata = s_q.gc9;
            default: s_d.rdata = 8'h00;
         endcase
      end

      // Storm metering per port; window length follows the port's speed
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (s_q.win_cnt[p] >= (port_is_10m[p] ? WIN_10_LAST : WIN_100_LAST)) begin
            s_d.win_cnt[p] = '0;
            s_d.blk_cnt[p] = '0;
            s_d.drop[p] = 1'b0;
         end else begin
            s_d.win_cnt[p] = s_q.win_cnt[p] + SGCR_WIN_W'(1);
            // Counter saturates at the threshold, so it never wraps
            if (storm_enable[p] && bcast_block[p] && s_q.blk_cnt[p] < threshold) begin
               s_d.blk_cnt[p] = s_q.blk_cnt[p] + SGCR_THR_W'(1);
            end
            s_d.drop[p] = storm_enable[p] && (s_d.blk_cnt[p] >= threshold);
         end
      end

      // Null VID replacement, one cycle of latency
      s_d.vid_valid = vid_valid_in;
      if (vid_valid_in && s_q.gc4[SGCR_BIT_NULL_VID] && vid_in == 12'h000) begin
         s_d.vid = port_vid;
      end else begin
         s_d.vid = vid_in;
      end

      // Loop-back frame verdict, one pulse per finished frame
      s_d.lb_fwd = 1'b0;
      s_d.lb_drop = 1'b0;
      if (loopback_mode && frame_done) begin
         if (frame_is_oam || (s_q.gc9[SGCR_BIT_CRC_DROP] && frame_bad)) begin
            s_d.lb_drop = 1'b1;
         end else begin
            s_d.lb_fwd = 1'b1;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.gc4 <= SGCR_RST_MII_VID_STORM_HIGH;
         s_q.storm_lo <= SGCR_RST_STORM_RATE_LOW;
         s_q.test_a <= SGCR_RST_FACTORY_TEST_A;
         s_q.test_b <= SGCR_RST_FACTORY_TEST_B;
         s_q.test_c <= SGCR_RST_FACTORY_TEST_C;
         s_q.gc9 <= SGCR_RST_LOOPBACK_LED_CONTROL;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs, all straight from flops
   assign reg_rdata = s_q.rdata;
   assign mii_10m_mode = s_q.gc4[SGCR_BIT_MII_10M];
   assign loopback_position_hi = s_q.gc9[SGCR_BIT_LB_POS_HI];
   assign loopback_position_lo = s_q.gc9[SGCR_BIT_LB_POS_LO];
   assign led_select_low = s_q.gc9[SGCR_BIT_LED_MODE];
   assign led_select_high = s_q.led_high;
   assign storm_drop = s_q.drop;
   assign vid_valid_out = s_q.vid_valid;
   assign vid_out = s_q.vid;
   assign loop_forward = s_q.lb_fwd;
   assign loop_drop = s_q.lb_drop;
endmodule

// ### verification/sgcr_top_sva.sv
/* Port checker for sgcr_top: register echo, VID pass, loop-back and storm gating.
   Assumes registers are written only after the straps have loaded. */
module sgcr_top_sva import sgcr_pkg::*; #(
   parameter int NUM_PORTS = 3
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic mii_10m_mode,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic loopback_position_hi,
   input wire logic loopback_position_lo,
   input wire logic led_select_low,
   input wire logic [NUM_PORTS-1:0] storm_enable,
   input wire logic [NUM_PORTS-1:0] storm_drop,
   input wire logic vid_valid_in,
   input wire logic vid_valid_out,
   input wire logic loopback_mode,
   input wire logic frame_done,
   input wire logic frame_is_oam,
   input wire logic loop_forward,
   input wire logic loop_drop,
   input wire logic [11:0] vid_in,
   input wire logic [11:0] vid_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Assertions
   a_storm_lo_rdback: assert property (reg_wr && reg_addr == SGCR_OFS_STORM_RATE_LOW ##2
      reg_rd && reg_addr == SGCR_OFS_STORM_RATE_LOW |=> reg_rdata == $past(reg_wdata, 3))
      else $error("storm threshold low byte not read back");
   a_speed_follow: assert property (reg_wr && reg_addr == SGCR_OFS_MII_VID_STORM_HIGH |=>
      mii_10m_mode == $past(reg_wdata[SGCR_BIT_MII_10M])) else $error("speed select mismatch");
   a_led_pos_follow: assert property (reg_wr && reg_addr == SGCR_OFS_LOOPBACK_LED_CONTROL |=>
      {loopback_position_hi, loopback_position_lo, led_select_low} == $past(reg_wdata[3:1]))
      else $error("loop-back position or LED bit mismatch");
   a_vid_pass: assert property (vid_valid_in && vid_in != 12'h000 |=>
      vid_valid_out && vid_out == $past(vid_in)) else $error("non-null VID altered");
   a_oam_drop: assert property (loopback_mode && frame_done && frame_is_oam |=>
      loop_drop && !loop_forward) else $error("OAM frame looped back");
   a_loop_one: assert property (loopback_mode && frame_done |=> loop_drop != loop_forward)
      else $error("loop-back verdict not exactly one");
   a_loop_quiet: assert property (!(loopback_mode && frame_done) |=> !loop_drop && !loop_forward)
      else $error("loop-back verdict without frame");
   a_storm_gate: assert property ((storm_drop & ~$past(storm_enable)) == '0)
      else $error("storm drop on a disabled port");
   c_drop: cover property (loop_drop);
   c_forward: cover property (loop_forward);
   c_storm: cover property ($rose(storm_drop[0]));
   c_vid: cover property (vid_valid_in && vid_in == 12'h000 ##1 vid_out != 12'h000);
endmodule
bind sgcr_top sgcr_top_sva #(.NUM_PORTS(NUM_PORTS)) i_sva (.*);

// ### verification/sgcr_host.sv
/* Management host model driving the register port.
   Assumes the slave never stalls and read data stand one cycle. */
module sgcr_host (
   input wire logic core_clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
   // Factory-test registers are only read, so they keep their reset values
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask
endmodule

// ### verification/tb_sgcr_top.sv
/* Self-checking bench for sgcr_top with short storm windows.
   Assumes the host model owns the register port; straps stay fixed. */
`define CHK(a, b) begin \
   n_compared++; \
   if ((a) !== (b)) begin \
      n_fail++; \
      $display("Error at %0t got %h exp %h", $time, (a), (b)); \
   end \
end
module tb_sgcr_top import sgcr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int W100 = 20;
   localparam int W10 = 50;
   // Straps all high except none: every strap-loaded bit is seen as a one
   localparam logic [7:0] RST_TBL [6] = '{8'h10, 8'h63, 8'h4e, 8'h24, 8'h24, 8'h0a};
   logic core_clk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, mii_10m_mode, led_select_low, led_select_high;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic mii_rx_bit1_strap = 1'b1, led_select_low_strap = 1'b1, led_select_high_strap = 1'b1;
   logic loopback_position_hi, loopback_position_lo, vid_valid_out, loop_forward, loop_drop;
   logic vid_valid_in = 1'b0, loopback_mode = 1'b0, frame_done = 1'b0, frame_is_oam = 1'b0;
   logic frame_crc_err = 1'b0, frame_undersize = 1'b0, frame_oversize = 1'b0;
   logic [2:0] port_is_10m = 3'h0, storm_enable = 3'h0, bcast_block = 3'h0, storm_drop;
   logic [11:0] vid_in = 12'h000, port_vid = 12'habc, vid_out;
   int n_fail = 0, n_compared = 0, n, i;
   sgcr_top #(.WIN_100_CYC(W100), .WIN_10_CYC(W10)) i_dut (.*);
   sgcr_host i_host (.*);
   initial forever #20 core_clk = ~core_clk;
   task automatic results();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      i_host.rd(a, d);
      `CHK(d, e)
   endtask
   task automatic frame(input logic [3:0] k, input logic [1:0] e);
      @(posedge core_clk);
      {frame_is_oam, frame_crc_err, frame_undersize, frame_oversize, frame_done} <= {k, 1'b1};
      @(posedge core_clk);
      frame_done <= 1'b0;
      @(negedge core_clk);
      `CHK(({loop_drop, loop_forward}), e)
   endtask
   // ==========================================================
   // Time between restarts, seen as falls of a threshold-zero drop
   task automatic period(input int w);
      for (i = 0; i < 200 && !storm_drop[0]; i++) @(negedge core_clk);
      for (i = 0; i < 200 && storm_drop[0]; i++) @(negedge core_clk);
      @(negedge core_clk);
      for (n = 1; n < 200 && storm_drop[0]; n++) @(negedge core_clk);
      `CHK(n, w)
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (8) @(negedge core_clk);
      `CHK(({mii_10m_mode, led_select_high, led_select_low}), 3'b111)
      for (int k = 0; k < 6; k++) rdchk(8'(k) + SGCR_OFS_MII_VID_STORM_HIGH, RST_TBL[k]);
      rdchk(8'h0c, 8'h00);
      i_host.wr(SGCR_OFS_MII_VID_STORM_HIGH, 8'he8);
      rdchk(SGCR_OFS_MII_VID_STORM_HIGH, 8'he8);
      `CHK(mii_10m_mode, 1'b0)
      i_host.wr(SGCR_OFS_STORM_RATE_LOW, 8'h5a);
      rdchk(SGCR_OFS_STORM_RATE_LOW, 8'h5a);
      i_host.wr(SGCR_OFS_LOOPBACK_LED_CONTROL, 8'hea);
      rdchk(SGCR_OFS_LOOPBACK_LED_CONTROL, 8'h6a);
      `CHK(({loopback_position_hi, loopback_position_lo, led_select_low}), 3'b101)
      @(posedge core_clk);
      vid_valid_in <= 1'b1;
      @(posedge core_clk);
      vid_in <= 12'h123;
      @(negedge core_clk);
      `CHK(({vid_valid_out, vid_out}), ({1'b1, 12'habc}))
      @(negedge core_clk);
      `CHK(vid_out, 12'h123)
      i_host.wr(SGCR_OFS_MII_VID_STORM_HIGH, 8'h00);
      vid_in <= 12'h000;
      repeat (2) @(negedge core_clk);
      `CHK(vid_out, 12'h000)
      @(posedge core_clk);
      loopback_mode <= 1'b1;
      for (n = 0; n < 5; n++) frame(4'(4'h8 >> n), {n != 4, n == 4});
      i_host.wr(SGCR_OFS_LOOPBACK_LED_CONTROL, 8'h08);
      for (n = 0; n < 5; n++) frame(4'(4'h8 >> n), {n == 0, n != 0});
      i_host.wr(SGCR_OFS_STORM_RATE_LOW, 8'h00);
      loopback_mode <= 1'b0;
      storm_enable <= 3'h1;
      // Outside loop-back mode an errored frame gets no verdict at all
      frame(4'h4, 2'b00);
      period(W100);
      @(posedge core_clk);
      port_is_10m <= 3'h1;
      period(W10);
      // Fresh window just began, so the steps below cannot straddle a restart
      @(posedge core_clk);
      storm_enable <= 3'h0;
      i_host.wr(SGCR_OFS_STORM_RATE_LOW, 8'h02);
      @(negedge core_clk);
      `CHK(storm_drop, 3'h0)
      @(posedge core_clk);
      storm_enable <= 3'h1;
      for (n = 1; n < 3; n++) begin
         @(posedge core_clk);
         bcast_block <= 3'h1;
         @(posedge core_clk);
         bcast_block <= 3'h0;
         @(negedge core_clk);
         `CHK(storm_drop, ({2'b00, n == 2}))
      end
      // Upper threshold bits lift the limit far above the two blocks counted
      i_host.wr(SGCR_OFS_MII_VID_STORM_HIGH, 8'h01);
      repeat (2) @(negedge core_clk);
      `CHK(storm_drop, 3'h0)
      results();
   end
   initial begin
      #400us;
      n_fail++;
      results();
   end
endmodule
